// file: inc/gpioi_pkg.sv
// Constants shared by the pin port and its input synchroniser
package gpioi_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_INPUT    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIR      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RISE_EN  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_HIGH_EN  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LOW_EN   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h20;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_OUTPUT   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DIR      = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_INT_EN   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IRQ_STAT = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IRQ_MASK = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RD_UNMAPPED  = 32'h0000_0000;

    // ==========================================================
    // Timing in clock cycles
    localparam int unsigned SYNC_STAGES   = 3;
    localparam int unsigned LAT_PIN_LEVEL = 4;

endpackage : gpioi_pkg

// file: inc/gpioi_sync_if.sv
// Interface carrying raw pins and their filtered level and edge pulses
`timescale 1ns/1ps
`default_nettype none

interface gpioi_sync_if #(
    parameter int unsigned W = 32
);
    logic [W-1:0] pin_raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport src (input pin_raw, output level, output rise, output fall);
    modport dst (output pin_raw, input level, input rise, input fall);
endinterface : gpioi_sync_if

`default_nettype wire

// file: logic/gpioi_sync.sv
// Per-pin input synchroniser, agreement filter and edge detector
`timescale 1ns/1ps
`default_nettype none

module gpioi_sync #(
    parameter int unsigned W = 32
) (
    input  wire logic clk,
    input  wire logic rst,
    gpioi_sync_if.src sio
);
    import gpioi_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] prev_reg;

    // ==========================================================
    // Synchroniser and filter
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_reg[i]  <= 1'b0;
                    s2_reg[i]    <= 1'b0;
                    s3_reg[i]    <= 1'b0;
                    level_reg[i] <= 1'b0;
                    prev_reg[i]  <= 1'b0;
                end else begin
                    meta_reg[i] <= sio.pin_raw[i];
                    s2_reg[i]   <= meta_reg[i];
                    s3_reg[i]   <= s2_reg[i];
                    // A change counts only once two late stages agree
                    if (s2_reg[i] == s3_reg[i]) begin
                        level_reg[i] <= s3_reg[i];
                    end
                    prev_reg[i] <= level_reg[i];
                end
            end
        end
    endgenerate

    // Edges from current sample against the previous one
    assign sio.level = level_reg;
    assign sio.rise  = level_reg & ~prev_reg;
    assign sio.fall  = ~level_reg & prev_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_level_agree: assert property (
        (level_reg != $past(level_reg)) |-> ($past(s2_reg) == $past(s3_reg)) && (level_reg == $past(s3_reg))
    ) else $error("level moved without stage agreement");

    a_edge_pulse: assert property (
        (|sio.rise) |=> ((sio.rise & $past(sio.rise)) == '0)
    ) else $error("rise pulse longer than one cycle");

endmodule : gpioi_sync

`default_nettype wire

// file: logic/gpioi_port.sv
// 32-bit pin port with direction, output value and pin interrupts
//
// Summary of operation
// - Direction bit one drives pin, zero inputs
// - Output value register drives pins, reads back
// - Direction register reads back as written
// - Enabled rising edge raises interrupt
// - Enabled falling edge raises interrupt
// - Enabled high level raises interrupt
// - Enabled low level raises interrupt
// - Input register reads sampled pin state
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module gpioi_port (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [gpioi_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [gpioi_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output var  logic [gpioi_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [gpioi_pkg::DATA_W-1:0]  pin_in,
    output var  logic [gpioi_pkg::DATA_W-1:0]  pin_out,
    output var  logic [gpioi_pkg::DATA_W-1:0]  pin_oe,
    output var  logic                          irq
);
    import gpioi_pkg::*;

    // ==========================================================
    // Declarations
    logic [DATA_W-1:0] out_reg;
    logic [DATA_W-1:0] dir_reg;
    logic [DATA_W-1:0] rise_en_reg;
    logic [DATA_W-1:0] fall_en_reg;
    logic [DATA_W-1:0] high_en_reg;
    logic [DATA_W-1:0] low_en_reg;
    logic [DATA_W-1:0] stat_reg;
    logic [DATA_W-1:0] stat_next;
    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] event_vec;
    logic [DATA_W-1:0] stat_clr;
    logic              irq_reg;
    logic              wr_out;
    logic              wr_dir;
    logic              wr_rise;
    logic              wr_fall;
    logic              wr_high;
    logic              wr_low;
    logic              wr_stat;
    logic              wr_mask;

    gpioi_sync_if #(.W(DATA_W)) sync_bus ();

    // ==========================================================
    // Input synchroniser
    assign sync_bus.pin_raw = pin_in;

    gpioi_sync #(
        .W   (DATA_W)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .sio (sync_bus.src)
    );

    // ==========================================================
    // Write decode
    assign wr_out  = reg_wr && (reg_addr == OFS_OUTPUT);
    assign wr_dir  = reg_wr && (reg_addr == OFS_DIR);
    assign wr_rise = reg_wr && (reg_addr == OFS_RISE_EN);
    assign wr_fall = reg_wr && (reg_addr == OFS_FALL_EN);
    assign wr_high = reg_wr && (reg_addr == OFS_HIGH_EN);
    assign wr_low  = reg_wr && (reg_addr == OFS_LOW_EN);
    assign wr_stat = reg_wr && (reg_addr == OFS_IRQ_STAT);
    assign wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);

    // ==========================================================
    // Output value and direction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= RST_OUTPUT;
        end else if (wr_out) begin
            out_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg <= RST_DIR;
        end else if (wr_dir) begin
            dir_reg <= reg_wdata;
        end
    end

    // Pins driven straight from the stored values
    assign pin_out = out_reg;
    assign pin_oe  = dir_reg;

    // ==========================================================
    // Interrupt enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_en_reg <= RST_INT_EN;
        end else if (wr_rise) begin
            rise_en_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fall_en_reg <= RST_INT_EN;
        end else if (wr_fall) begin
            fall_en_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high_en_reg <= RST_INT_EN;
        end else if (wr_high) begin
            high_en_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_en_reg <= RST_INT_EN;
        end else if (wr_low) begin
            low_en_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= RST_IRQ_MASK;
        end else if (wr_mask) begin
            mask_reg <= reg_wdata;
        end
    end

    // ==========================================================
    // Per-pin events and sticky status
    // Output pins are watched too, so software can loop back its own drive
    assign event_vec = (sync_bus.rise  & rise_en_reg)
                     | (sync_bus.fall  & fall_en_reg)
                     | (sync_bus.level & high_en_reg)
                     | (~sync_bus.level & low_en_reg);

    assign stat_clr  = wr_stat ? reg_wdata : '0;

    // Set beats clear; a held level re-arms its bit at once
    assign stat_next = (stat_reg & ~stat_clr) | event_vec;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_reg <= RST_IRQ_STAT;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // One cycle behind status, kept registered for a clean output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    assign irq = irq_reg;

    // ==========================================================
    // Read path
    always_comb begin
        rdata_next = RD_UNMAPPED;
        unique case (reg_addr)
            OFS_INPUT:    rdata_next = sync_bus.level;
            OFS_OUTPUT:   rdata_next = out_reg;
            OFS_DIR:      rdata_next = dir_reg;
            OFS_RISE_EN:  rdata_next = rise_en_reg;
            OFS_FALL_EN:  rdata_next = fall_en_reg;
            OFS_HIGH_EN:  rdata_next = high_en_reg;
            OFS_LOW_EN:   rdata_next = low_en_reg;
            OFS_IRQ_STAT: rdata_next = stat_reg;
            OFS_IRQ_MASK: rdata_next = mask_reg;
            default:      rdata_next = RD_UNMAPPED;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RD_UNMAPPED;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= RD_UNMAPPED;
        end
    end

    assign reg_rdata = rdata_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr_dir;
        wr_dir;
    endsequence

    sequence s_wr_out;
        wr_out;
    endsequence

    sequence s_rd_at(logic [ADDR_W-1:0] ofs);
        reg_rd && (reg_addr == ofs);
    endsequence

    a_dir_drive: assert property (
        s_wr_dir |=> (pin_oe == $past(reg_wdata)) && (dir_reg == pin_oe)
    ) else $error("direction write not seen on output enables");

    a_out_drive: assert property (
        s_wr_out |=> (pin_out == $past(reg_wdata))
    ) else $error("output write not seen on pins");

    a_out_readback: assert property (
        s_rd_at(OFS_OUTPUT) |=> (reg_rdata == pin_out)
    ) else $error("output readback differs from driven pins");

    a_dir_readback: assert property (
        (s_wr_dir ##1 s_rd_at(OFS_DIR)) |=> (reg_rdata == $past(reg_wdata, 2))
    ) else $error("direction readback differs from last write");

    a_rise_status: assert property (
        (|(sync_bus.rise & rise_en_reg))
            |=> ((stat_reg & $past(sync_bus.rise & rise_en_reg)) == $past(sync_bus.rise & rise_en_reg))
    ) else $error("enabled rising edge did not set status");

    a_fall_status: assert property (
        (|(sync_bus.fall & fall_en_reg))
            |=> ((stat_reg & $past(sync_bus.fall & fall_en_reg)) == $past(sync_bus.fall & fall_en_reg))
    ) else $error("enabled falling edge did not set status");

    a_high_status: assert property (
        (|(sync_bus.level & high_en_reg))
            |=> ((stat_reg & $past(sync_bus.level & high_en_reg)) == $past(sync_bus.level & high_en_reg))
    ) else $error("enabled high level did not set status");

    a_low_status: assert property (
        (|(~sync_bus.level & low_en_reg))
            |=> ((stat_reg & $past(~sync_bus.level & low_en_reg)) == $past(~sync_bus.level & low_en_reg))
    ) else $error("enabled low level did not set status");

    a_input_read: assert property (
        s_rd_at(OFS_INPUT) |=> (reg_rdata == $past(sync_bus.level))
    ) else $error("input read differs from sampled pins");

    a_irq_gate: assert property (
        irq == $past(|(stat_reg & mask_reg))
    ) else $error("interrupt output not the masked status OR");

    a_rd_idle_zero: assert property (
        !reg_rd |=> (reg_rdata == RD_UNMAPPED)
    ) else $error("read data present without a read strobe");

endmodule : gpioi_port

`default_nettype wire

// file: tb/gpioi_pin_model.sv
// External pin model: driven pins loop back, the rest follow an outside source
`timescale 1ns/1ps
`default_nettype none

module gpioi_pin_model (
    input  wire logic [gpioi_pkg::DATA_W-1:0] pin_out,
    input  wire logic [gpioi_pkg::DATA_W-1:0] pin_oe,
    input  wire logic [gpioi_pkg::DATA_W-1:0] ext_drive,
    output var  logic [gpioi_pkg::DATA_W-1:0] pin_in
);
    import gpioi_pkg::*;
    // A driven pin shows the port's own value, so no contention on the wire
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
    end
endmodule : gpioi_pin_model

`default_nettype wire

// file: tb/test_gpioi_port.sv
// Self-checking bench for the pin port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module test_gpioi_port;
    import gpioi_pkg::*;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] pin_in;
    logic [DATA_W-1:0] pin_out;
    logic [DATA_W-1:0] pin_oe;
    logic              irq;
    logic [DATA_W-1:0] ext;
    logic [31:0]       seed = 32'h1bae;
    int                fails = 0;
    int                checks = 0;

    gpioi_port u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    gpioi_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext), .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic stop_test();
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe, so sample it there
    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask : chk_rd

    // Write then read one word with no idle cycle between the two strobes
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] e);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("write then read", e, reg_rdata)
    endtask : wr_rd

    // Pin starts at v0, moves to v1; level kinds keep status set through a clear
    task automatic evt(input logic [ADDR_W-1:0] en, input logic v0, input logic v1, input logic lvl);
        int                b;
        logic [DATA_W-1:0] m;
        b = int'(xs() % 32);
        m = 32'h1 << b;
        ext[b] <= v0;
        repeat (8) @(posedge clk);
        wr(OFS_IRQ_STAT, 32'hffff_ffff);
        wr(OFS_IRQ_MASK, m);
        wr(en, m);
        chk_rd(OFS_IRQ_STAT, 32'h0, "status before event");
        `CHK("irq before event", 1'b0, irq)
        @(posedge clk);
        ext[b] <= v1;
        repeat (8) @(posedge clk);
        chk_rd(OFS_IRQ_STAT, m, "status after event");
        `CHK("irq after event", 1'b1, irq)
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_IRQ_STAT, m);
        chk_rd(OFS_IRQ_STAT, lvl ? m : 32'h0, "status after clear");
        // Back to the first state: the opposite edge or level must not set status
        @(posedge clk);
        ext[b] <= v0;
        repeat (8) @(posedge clk);
        wr(OFS_IRQ_STAT, lvl ? m : 32'h0);
        chk_rd(OFS_IRQ_STAT, 32'h0, "opposite state");
        wr(en, 32'h0);
        wr(OFS_IRQ_STAT, 32'hffff_ffff);
        chk_rd(OFS_IRQ_STAT, 32'h0, "status disabled");
    endtask : evt

    // ==========================================================
    // Main sequence
    logic [ADDR_W-1:0] offs [9] = '{OFS_INPUT, OFS_OUTPUT, OFS_DIR, OFS_RISE_EN, OFS_FALL_EN,
        OFS_HIGH_EN, OFS_LOW_EN, OFS_IRQ_STAT, OFS_IRQ_MASK};

    initial begin
        logic [DATA_W-1:0] o;
        logic [DATA_W-1:0] dr;
        logic [DATA_W-1:0] x;
        rst       = 1'b1;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        ext       = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            chk_rd(offs[i], 32'h0, "reset value");
        end
        `CHK("pin_oe reset", 32'h0, pin_oe)
        `CHK("irq reset", 1'b0, irq)
        for (int k = 0; k < 8; k++) begin
            o  = (k == 0) ? 32'hffff_ffff : xs();
            dr = (k == 1) ? 32'hffff_ffff : xs();
            x  = xs();
            ext <= x;
            wr(OFS_OUTPUT, o);
            wr_rd(OFS_DIR, dr, dr);
            @(posedge clk);
            #1;
            `CHK("pin_out", o, pin_out)
            `CHK("pin_oe", dr, pin_oe)
            chk_rd(OFS_OUTPUT, o, "output readback");
            chk_rd(OFS_DIR, dr, "direction readback");
            chk_rd(OFS_INPUT, (dr & o) | (~dr & x), "input value");
        end
        // Writes to the input word and to unmapped space must leave no trace
        wr(OFS_INPUT, 32'h0);
        chk_rd(OFS_INPUT, (dr & o) | (~dr & x), "input after write");
        wr(8'h24, 32'hffff_ffff);
        chk_rd(8'h24, 32'h0, "unmapped read");
        // Level enables above leave sticky bits, so the status word is cleared in full
        for (int i = 3; i < 9; i++) begin
            x = (i == 7) ? 32'hffff_ffff : xs();
            wr(offs[i], x);
            chk_rd(offs[i], (i == 7) ? 32'h0 : x, "enable readback");
            wr(offs[i], 32'h0);
        end
        wr(OFS_DIR, 32'h0);
        evt(OFS_RISE_EN, 1'b0, 1'b1, 1'b0);
        evt(OFS_FALL_EN, 1'b1, 1'b0, 1'b0);
        evt(OFS_HIGH_EN, 1'b0, 1'b1, 1'b1);
        evt(OFS_LOW_EN, 1'b1, 1'b0, 1'b1);
        stop_test();
    end

    // Whole run is a few hundred cycles; this bound is far beyond it
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule : test_gpioi_port

`default_nettype wire
